// [pkg/spic_pkg.sv]
// constants, field layouts and types shared by the serial port block
`default_nettype none
package spic_pkg;
  localparam int AW = 8;
  localparam int DW = 4;
  localparam logic [AW-1:0] OFF_MODE     = 8'hc8;
  localparam logic [AW-1:0] OFF_CLK      = 8'hc9;
  localparam logic [AW-1:0] OFF_CTRL     = 8'hca;
  localparam logic [AW-1:0] OFF_ERR      = 8'hcb;
  localparam logic [AW-1:0] OFF_DATA_LO  = 8'hcc;
  localparam logic [AW-1:0] OFF_DATA_HI  = 8'hcd;
  localparam logic [AW-1:0] OFF_MASK     = 8'hf1;
  localparam logic [AW-1:0] OFF_FLAGS    = 8'hf9;
  localparam logic [AW-1:0] OFF_FLAG_CLR = 8'hfa;
  localparam int FLAG_RX   = 0;
  localparam int FLAG_TX   = 1;
  localparam int FLAG_ERR  = 2;
  localparam int CTRL_TX_ENABLE_BIT = 0;
  localparam int CTRL_TX_TRIGGER = 1;
  localparam int CTRL_RX_ENABLE_BIT = 2;
  localparam int CTRL_RX_TRIGGER = 3;
  localparam int ERR_OVR   = 0;
  localparam int ERR_PAR   = 1;
  localparam int ERR_FRM   = 2;
  localparam int CLK_PKIND = 2;
  localparam int CLK_PON   = 3;
  localparam int MODE_LSB  = 1;
  localparam logic [DW-1:0] NIBBLE_RESET = 4'h0;
  localparam logic [7:0]    DATA_RESET   = 8'h00;
  localparam logic [2:0]    HALF_DIV16   = 3'h7;
  localparam logic [2:0]    HALF_DIV8    = 3'h3;
  localparam logic [2:0]    HALF_DIV4    = 3'h1;
  typedef enum logic [1:0] {
    MODE_SYNC_MASTER = 2'b00,
    MODE_SYNC_SLAVE  = 2'b01,
    MODE_ASYNC7      = 2'b10,
    MODE_ASYNC8      = 2'b11
  } spic_mode_t;
  typedef enum logic [1:0] {
    CS_DIV16 = 2'b00,
    CS_DIV8  = 2'b01,
    CS_DIV4  = 2'b10,
    CS_TIMER = 2'b11
  } spic_clksrc_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_DATA = 2'b01,
    RX_STOP = 2'b10,
    RX_DONE = 2'b11
  } spic_rx_state_t;
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } spic_bus_t;
endpackage
`default_nettype wire

// [rtl/spic_baud.sv]
// serial clock divider: one pulse per half serial clock period
`default_nettype none
module spic_baud (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire spic_pkg::spic_clksrc_t src,
  input  wire logic                  timer_uf,
  output logic                       tick
);
  import spic_pkg::*;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] top;

  always_comb begin
    case (src)
      CS_DIV16: top = HALF_DIV16;
      CS_DIV8:  top = HALF_DIV8;
      CS_DIV4:  top = HALF_DIV4;
      default:  top = HALF_DIV4;
    endcase
    cnt_next = (cnt_reg >= top) ? 3'h0 : cnt_reg + 3'h1;
    // timer source: serial clock is half the underflow rate, so each underflow is a half period
    tick = (src == CS_TIMER) ? timer_uf : (cnt_reg >= top);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // spic_baud
`default_nettype wire

// [rtl/spic_tx.sv]
// transmit frame builder and shifter
`default_nettype none
module spic_tx (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic       async,
  input  wire logic       bits8,
  input  wire logic       par_on,
  input  wire logic       par_odd,
  input  wire logic       shift_p,
  output logic            line,
  output logic            busy,
  output logic            done
);
  import spic_pkg::*;
  logic [10:0] sr_reg, sr_next, frame;
  logic [3:0]  cnt_reg, cnt_next, len_reg, len_next, len;
  logic        busy_next, line_reg, line_next;
  logic [7:0]  data_reg, data_next, d;
  logic        par;

  always_comb begin
    d = bits8 ? data : {1'b0, data[6:0]};
    par = par_odd ? ~(^d) : ^d;
    frame = '1;
    if (async) begin
      frame[0] = 1'b0;
      if (bits8) begin
        frame[8:1] = d;
        frame[9] = par_on ? par : 1'b1;
      end else begin
        frame[7:1] = d[6:0];
        frame[8] = par_on ? par : 1'b1;
      end
      len = 4'(bits8 ? 10 : 9) + 4'(par_on);
    end else begin
      frame[7:0] = data;
      len = 4'h8;
    end
    sr_next = sr_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    busy_next = busy;
    line_next = line_reg;
    data_next = data_reg;
    done = 1'b0;
    if (start && !busy) begin
      sr_next = frame;
      len_next = len;
      cnt_next = 4'h0;
      busy_next = 1'b1;
      data_next = data;
    end else if (busy && shift_p) begin
      if (cnt_reg == len_reg) begin
        busy_next = 1'b0;
        line_next = 1'b1;
        done = 1'b1;
      end else begin
        line_next = sr_reg[0];
        sr_next = {1'b1, sr_reg[10:1]};
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_reg <= '1;
      cnt_reg <= 4'h0;
      len_reg <= 4'h0;
      busy <= 1'b0;
      line_reg <= 1'b1;
      data_reg <= DATA_RESET;
    end else begin
      sr_reg <= sr_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      busy <= busy_next;
      line_reg <= line_next;
      data_reg <= data_next;
    end
  end
  assign line = line_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_first_bit_lsb: assert property ((busy && shift_p && cnt_reg == 4'h0 && !async)
    |=> line == data_reg[0]) else $error("first sync bit is not the lsb");
  a_async_start_low: assert property ((busy && shift_p && cnt_reg == 4'h0 && async)
    |=> line == 1'b0) else $error("async frame does not open with a low start bit");
endmodule // spic_tx
`default_nettype wire

// [rtl/spic_top.sv]
// serial port with interrupt flags, control registers and receiver
`default_nettype none
module spic_top (
  input  wire logic               CLOCK,
  input  wire logic               RESET,
  input  wire spic_pkg::spic_bus_t BUS,
  output logic [spic_pkg::DW-1:0] RDATA,
  output logic                    IRQ,
  input  wire logic               TIMER_UNDERFLOW,
  input  wire logic               SERIAL_IN,
  output logic                    SERIAL_OUT,
  input  wire logic               SCLK_IN,
  output logic                    SCLK_OUT,
  output logic                    SCLK_OE
);
  import spic_pkg::*;

  spic_mode_t     mode_reg, mode_next;
  spic_clksrc_t   cs_reg, cs_next;
  spic_rx_state_t rx_state, rx_state_next;
  logic           pkind_reg, pkind_next, pon_reg, pon_next;
  logic           tx_enable_bit_reg, tx_enable_bit_next, rx_enable_bit_reg, rx_enable_bit_next, rxbusy_reg, rxbusy_next;
  logic [2:0]     errf_reg, errf_next, flag_reg, flag_next, mask_reg, mask_next;
  logic [7:0]     data_reg, data_next, rx_sr, rx_sr_next;
  logic [3:0]     rx_cnt, rx_cnt_next, rdata_next;
  logic           rx_full, rx_full_next, rx_par, rx_par_next, ovr_reg, ovr_next;
  logic           phase_reg, phase_next, sclk_q, tick, fall_p, rise_p;
  logic           async, sync_slave, bits8, par_act, tx_busy, tx_done, tx_line, tx_start;
  logic           wr_ctrl, err_now, err_set, rx_set, any_en;
  logic [3:0]     nbits;

  assign async = mode_reg[1];
  assign sync_slave = (mode_reg == MODE_SYNC_SLAVE);
  assign bits8 = (mode_reg != MODE_ASYNC7);
  assign par_act = async && pon_reg;
  assign nbits = 4'(bits8 ? 8 : 7) + 4'(par_act);
  assign any_en = tx_enable_bit_reg || rx_enable_bit_reg;
  assign wr_ctrl = BUS.wr && BUS.addr == OFF_CTRL;

  spic_baud u_baud (
    .clk      (CLOCK),
    .rst      (RESET),
    .src      (cs_reg),
    .timer_uf (TIMER_UNDERFLOW),
    .tick     (tick)
  );

  // slave edges come from the pin; master and async edges come from the divider
  always_comb begin
    phase_next = tick ? ~phase_reg : phase_reg;
    if (sync_slave) begin
      fall_p = sclk_q && !SCLK_IN;
      rise_p = !sclk_q && SCLK_IN;
    end else begin
      fall_p = tick && phase_reg;
      rise_p = tick && !phase_reg;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      phase_reg <= 1'b1;
      sclk_q <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      sclk_q <= SCLK_IN;
    end
  end

  // a trigger is refused while the line is shared with a running opposite direction
  assign tx_start = wr_ctrl && BUS.wdata[CTRL_TX_TRIGGER] && (tx_enable_bit_reg || BUS.wdata[CTRL_TX_ENABLE_BIT])
                    && !tx_busy && !(!async && rxbusy_reg);

  spic_tx u_tx (
    .clk     (CLOCK),
    .rst     (RESET),
    .start   (tx_start),
    .data    (data_reg),
    .async   (async),
    .bits8   (bits8),
    .par_on  (par_act),
    .par_odd (pkind_reg),
    .shift_p (fall_p),
    .line    (tx_line),
    .busy    (tx_busy),
    .done    (tx_done)
  );

  // receiver: sample on rise, report on the following fall
  always_comb begin
    rx_state_next = rx_state;
    rx_sr_next = rx_sr;
    rx_cnt_next = rx_cnt;
    rx_par_next = rx_par;
    ovr_next = ovr_reg;
    err_now = 1'b0;
    err_set = 1'b0;
    rx_set = 1'b0;
    case (rx_state)
      RX_IDLE: begin
        if (rxbusy_reg && rise_p && (!async || !SERIAL_IN)) begin
          rx_cnt_next = 4'h0;
          if (!async) begin
            rx_sr_next = {SERIAL_IN, rx_sr[7:1]};
            rx_cnt_next = 4'h1;
          end
          rx_state_next = RX_DATA;
        end
      end
      RX_DATA: begin
        if (rise_p) begin
          if (rx_cnt < (bits8 ? 4'h8 : 4'h7)) begin
            rx_sr_next = {SERIAL_IN, rx_sr[7:1]};
          end else begin
            rx_par_next = SERIAL_IN;
          end
          rx_cnt_next = rx_cnt + 4'h1;
          if (rx_cnt + 4'h1 == (async ? nbits : 4'h8)) begin
            rx_state_next = async ? RX_STOP : RX_DONE;
            ovr_next = !async && rx_full;
          end
        end
      end
      RX_STOP: begin
        if (rise_p) begin
          // a 7-bit frame leaves a stale bit at the bottom of the shifter, so it stays out of the parity
          err_now = !SERIAL_IN ||
                    (par_act && (rx_par != (pkind_reg ^ (bits8 ? ^rx_sr : ^rx_sr[7:1]))));
          err_set = err_now;
          ovr_next = rx_full;
          rx_state_next = RX_DONE;
        end
      end
      RX_DONE: begin
        if (fall_p) begin
          rx_set = !ovr_reg;
          rx_state_next = RX_IDLE;
        end
      end
      default: rx_state_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      rx_state <= RX_IDLE;
      rx_sr <= DATA_RESET;
      rx_cnt <= 4'h0;
      rx_par <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      rx_state <= rx_state_next;
      rx_sr <= rx_sr_next;
      rx_cnt <= rx_cnt_next;
      rx_par <= rx_par_next;
      ovr_reg <= ovr_next;
    end
  end

  // register file
  always_comb begin
    mode_next = mode_reg;
    cs_next = cs_reg;
    pkind_next = pkind_reg;
    pon_next = pon_reg;
    tx_enable_bit_next = tx_enable_bit_reg;
    rx_enable_bit_next = rx_enable_bit_reg;
    mask_next = mask_reg;
    data_next = data_reg;
    rxbusy_next = rxbusy_reg;
    rx_full_next = rx_full;
    errf_next = errf_reg;
    flag_next = flag_reg;
    rdata_next = NIBBLE_RESET;
    if (BUS.wr) begin
      case (BUS.addr)
        // a mode change under a live transfer would corrupt the frame, so a mode write is ignored while either enable bit is set
        OFF_MODE: if (!any_en) mode_next = spic_mode_t'(BUS.wdata[MODE_LSB+1:MODE_LSB]);
        OFF_CLK: begin
          if (!any_en) cs_next = spic_clksrc_t'(BUS.wdata[1:0]);
          pkind_next = BUS.wdata[CLK_PKIND];
          pon_next = BUS.wdata[CLK_PON];
        end
        OFF_CTRL: begin
          tx_enable_bit_next = BUS.wdata[CTRL_TX_ENABLE_BIT];
          rx_enable_bit_next = BUS.wdata[CTRL_RX_ENABLE_BIT];
        end
        OFF_ERR: errf_next = errf_reg & ~BUS.wdata[2:0];
        OFF_DATA_LO: data_next[3:0] = BUS.wdata;
        OFF_DATA_HI: data_next[7:4] = BUS.wdata;
        OFF_MASK: mask_next = BUS.wdata[2:0];
        OFF_FLAG_CLR: flag_next = flag_reg & ~BUS.wdata[2:0];
        default: ;
      endcase
    end
    if (BUS.rd) begin
      case (BUS.addr)
        OFF_MODE: rdata_next = {1'b0, mode_reg, 1'b0};
        OFF_CLK: rdata_next = {pon_reg, pkind_reg, cs_reg};
        OFF_CTRL: rdata_next = {rxbusy_reg, rx_enable_bit_reg, tx_busy, tx_enable_bit_reg};
        OFF_ERR: rdata_next = {1'b0, errf_reg};
        OFF_DATA_LO: rdata_next = data_reg[3:0];
        OFF_DATA_HI: begin
          rdata_next = data_reg[7:4];
          rx_full_next = 1'b0;
        end
        OFF_MASK: rdata_next = {1'b0, mask_reg};
        OFF_FLAGS: begin
          rdata_next = {1'b0, flag_reg};
          flag_next = 3'h0;
        end
        default: rdata_next = NIBBLE_RESET;
      endcase
    end
    if (wr_ctrl && BUS.wdata[CTRL_RX_TRIGGER] && (rx_enable_bit_reg || BUS.wdata[CTRL_RX_ENABLE_BIT])
        && !(!async && tx_busy)) begin
      rxbusy_next = 1'b1;
    end
    if (!rx_enable_bit_next || (rx_set && !async)) begin
      rxbusy_next = 1'b0;
    end
    if (rx_set) begin
      data_next = bits8 ? rx_sr : {1'b0, rx_sr[7:1]};
      rx_full_next = 1'b1;
    end
    // hardware sets win over software clears in the same cycle
    if (err_set) begin
      errf_next[ERR_FRM] = errf_next[ERR_FRM] | !SERIAL_IN;
      errf_next[ERR_PAR] = errf_next[ERR_PAR] | SERIAL_IN;
    end
    if (ovr_next && !ovr_reg) begin
      errf_next[ERR_OVR] = 1'b1;
    end
    flag_next[FLAG_ERR] = flag_next[FLAG_ERR] | err_set | (ovr_next && !ovr_reg);
    flag_next[FLAG_TX] = flag_next[FLAG_TX] | tx_done;
    flag_next[FLAG_RX] = flag_next[FLAG_RX] | rx_set;
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      mode_reg <= MODE_SYNC_MASTER;
      cs_reg <= CS_DIV16;
      pkind_reg <= 1'b0;
      pon_reg <= 1'b0;
      tx_enable_bit_reg <= 1'b0;
      rx_enable_bit_reg <= 1'b0;
      mask_reg <= 3'h0;
      data_reg <= DATA_RESET;
      rxbusy_reg <= 1'b0;
      rx_full <= 1'b0;
      errf_reg <= 3'h0;
      flag_reg <= 3'h0;
      RDATA <= NIBBLE_RESET;
      SERIAL_OUT <= 1'b1;
      SCLK_OUT <= 1'b1;
      SCLK_OE <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      cs_reg <= cs_next;
      pkind_reg <= pkind_next;
      pon_reg <= pon_next;
      tx_enable_bit_reg <= tx_enable_bit_next;
      rx_enable_bit_reg <= rx_enable_bit_next;
      mask_reg <= mask_next;
      data_reg <= data_next;
      rxbusy_reg <= rxbusy_next;
      rx_full <= rx_full_next;
      errf_reg <= errf_next;
      flag_reg <= flag_next;
      RDATA <= rdata_next;
      SERIAL_OUT <= tx_line;
      SCLK_OUT <= (mode_reg == MODE_SYNC_MASTER) ? phase_next : 1'b1;
      SCLK_OE <= (mode_reg == MODE_SYNC_MASTER) && (tx_busy || rxbusy_reg);
    end
  end

  assign IRQ = |(flag_reg & mask_reg);

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_flags_read_clear: assert property ((BUS.rd && BUS.addr == OFF_FLAGS && !err_set && !tx_done && !rx_set &&
    !(ovr_next && !ovr_reg)) |=> flag_reg == 3'h0) else $error("flag nibble not cleared by read");
  a_flag_top_zero: assert property ((BUS.rd && BUS.addr == OFF_FLAGS) |=> RDATA[3] == 1'b0)
    else $error("unused flag bit reads nonzero");
  a_err_leads_rx: assert property ((rx_state == RX_STOP && rise_p && err_now)
    |=> (flag_reg[FLAG_ERR] && rx_state == RX_DONE && !rx_set)) else $error("error flag does not lead receive done");
  a_overrun_silent: assert property ((rx_state == RX_DONE && ovr_reg) |-> !rx_set)
    else $error("receive done raised on overrun");
  a_tx_done_flag: assert property (tx_done |=> (flag_reg[FLAG_TX] && !tx_busy))
    else $error("transmit done flag missing after frame");
  a_trigger_runs: assert property (tx_start |=> tx_busy ##1 1'b1)
    else $error("transmit trigger did not start transfer");
  a_sync_one_way: assert property (!async |-> !(tx_busy && rxbusy_reg))
    else $error("both directions running in synchronous mode");
  a_err_write_clear: assert property ((BUS.wr && BUS.addr == OFF_ERR && BUS.wdata[ERR_OVR] &&
    !(ovr_next && !ovr_reg)) |=> !errf_reg[ERR_OVR]) else $error("overrun flag not cleared by write");
  a_parity_async_only: assert property ((!async && rx_state == RX_DATA && rise_p && rx_cnt == 4'h7)
    |=> rx_state == RX_DONE) else $error("parity bit taken in synchronous mode");
  a_master_clock_out: assert property ((mode_reg == MODE_SYNC_MASTER && tx_busy) |=> SCLK_OE)
    else $error("master does not drive serial clock");
  a_irq_follows_flag: assert property ((tx_done && mask_reg[FLAG_TX] && !(BUS.wr && BUS.addr == OFF_MASK))
    |=> IRQ) else $error("enabled transmit flag raises no interrupt");

  c_tx_frame: cover property (tx_done);
  c_rx_frame: cover property (rx_set);
  c_rx_error: cover property (err_set ##[1:40] rx_state == RX_IDLE);
  c_overrun: cover property (ovr_next && !ovr_reg);
endmodule // spic_top
`default_nettype wire

// [testbench/spic_remote.sv]
// remote serial device: async 8-bit frame receiver and sender on the data lines
`default_nettype none
module spic_remote #(
  parameter int BIT = 4
) (
  input  wire logic  clk,
  input  wire logic  line_in,
  output logic       line_out,
  output logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ns;

  int frames = 0;

  initial begin
    line_out = 1'b1;
    got_byte = 8'h00;
  end

  // sample each bit in its middle, least significant bit first
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      got_byte[i] = line_in;
    end
    repeat (BIT) @(posedge clk);
    frames++;
  end

  // start bit, eight data bits lsb first, stop bit; a stop of 0 makes a framing fault
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
  endtask
endmodule // spic_remote
`default_nettype wire

// [testbench/spic_top_bench.sv]
// self-checking bench for the serial port block
`default_nettype none
module spic_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import spic_pkg::*;

  logic          CLOCK = 1'b0;
  logic          RESET = 1'b1;
  logic          TIMER_UNDERFLOW = 1'b0;
  spic_bus_t     BUS = '0;
  logic [DW-1:0] RDATA;
  logic          IRQ;
  logic          SERIAL_IN;
  logic          SERIAL_OUT;
  logic          SCLK_OUT;
  logic          SCLK_OE;
  logic [7:0]    got_byte;
  logic [7:0]    b;
  logic [7:0]    b2;
  logic          rd_pend = 1'b0;
  logic [11:0]   notes[$];
  int            err_count = 0;
  int            checked = 0;
  int            seed = 94;
  int            cycles = 0;
  int            old;

  always #25 CLOCK = ~CLOCK;

  spic_top i_spic_top (
    .CLOCK(CLOCK), .RESET(RESET), .BUS(BUS), .RDATA(RDATA), .IRQ(IRQ), .TIMER_UNDERFLOW(TIMER_UNDERFLOW),
    .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT), .SCLK_IN(1'b1), .SCLK_OUT(SCLK_OUT), .SCLK_OE(SCLK_OE)
  );

  spic_remote #(.BIT(4)) i_spic_remote (
    .clk(CLOCK), .line_in(SERIAL_OUT), .line_out(SERIAL_IN), .got_byte(got_byte)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge CLOCK) begin
    rd_pend <= BUS.rd;
    cycles <= cycles + 1;
    // an underflow every other cycle gives the same bit time as the /4 divider
    TIMER_UNDERFLOW <= cycles[0];
    if (rd_pend) begin
      check($sformatf("read %h", notes[0][11:4]), {4'h0, RDATA}, {4'h0, notes[0][3:0]});
      void'(notes.pop_front());
    end
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    BUS <= '{a, d, 1'b1, 1'b0};
    @(posedge CLOCK);
    BUS <= '{a, d, 1'b0, 1'b0};
    @(posedge CLOCK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    notes.push_back({a, e});
    BUS <= '{a, 4'h0, 1'b0, 1'b1};
    @(posedge CLOCK);
    BUS <= '{a, 4'h0, 1'b0, 1'b0};
    @(posedge CLOCK);
  endtask

  // bounded wait for the interrupt line, sampled away from the launching edge
  task automatic wait_irq;
    for (int i = 0; i < 300 && IRQ !== 1'b1; i++) @(negedge CLOCK);
    @(negedge CLOCK);
    check("irq", {7'h0, IRQ}, 8'h01);
    @(posedge CLOCK);
  endtask

  initial begin
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK);
    check("reset outputs", {4'h0, SCLK_OUT, SCLK_OE, SERIAL_OUT, IRQ}, 8'h0a);
    @(posedge CLOCK);
    RESET <= 1'b0;
    @(posedge CLOCK);
    rd(OFF_FLAGS, 4'h0);
    rd(OFF_CTRL, 4'h0);
    rd(8'h00, 4'h0);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_MODE, {1'b0, 2'(m), 1'b0});
      rd(OFF_MODE, {1'b0, 2'(m), 1'b0});
    end
    wr(OFF_CLK, 4'h2); // cpu divider, so no oscillator settling wait
    rd(OFF_CLK, 4'h2);
    wr(OFF_MASK, 4'h7); // no cpu interrupt is running here
    rd(OFF_MASK, 4'h7);
    repeat (3) begin
      b = 8'($random(seed));
      old = i_spic_remote.frames;
      wr(OFF_DATA_LO, b[3:0]);
      wr(OFF_DATA_HI, b[7:4]);
      wr(OFF_CTRL, 4'h3); // one trigger per frame
      rd(OFF_CTRL, 4'h3);
      wr(OFF_MODE, 4'h0);
      rd(OFF_MODE, 4'h6);
      wait_irq();
      for (int i = 0; i < 100 && i_spic_remote.frames == old; i++) @(posedge CLOCK);
      check("tx byte", got_byte, b);
      rd(OFF_FLAGS, 4'h2); // no handler runs, so the shared read loses nothing
      rd(OFF_FLAGS, 4'h0);
      rd(OFF_CTRL, 4'h1);
    end
    wr(OFF_CTRL, 4'h0);
    wr(OFF_CTRL, 4'h4);
    wr(OFF_CTRL, 4'hc);
    b = 8'($random(seed));
    b2 = 8'($random(seed));
    i_spic_remote.send(b, 1'b1);
    wait_irq();
    rd(OFF_FLAGS, 4'h1);
    rd(OFF_DATA_LO, b[3:0]);
    rd(OFF_DATA_HI, b[7:4]);
    i_spic_remote.send(b2, 1'b1);
    wait_irq();
    rd(OFF_FLAGS, 4'h1);
    // third frame lands while the second is still unread: overrun
    i_spic_remote.send(b, 1'b1);
    wait_irq();
    rd(OFF_FLAGS, 4'h4);
    rd(OFF_ERR, 4'h1);
    rd(OFF_DATA_HI, b2[7:4]);
    wr(OFF_ERR, 4'h1);
    rd(OFF_ERR, 4'h0);
    // timer underflow as clock source; the source is taken only while both directions are off
    wr(OFF_CTRL, 4'h0);
    wr(OFF_CLK, 4'h3);
    rd(OFF_CLK, 4'h3);
    wr(OFF_CTRL, 4'hc);
    wr(OFF_MASK, 4'h0);
    i_spic_remote.send(b, 1'b0);
    repeat (8) @(posedge CLOCK);
    @(negedge CLOCK);
    check("irq masked", {7'h0, IRQ}, 8'h00);
    wr(OFF_MASK, 4'h4);
    wait_irq();
    rd(OFF_FLAGS, 4'h5);
    rd(OFF_ERR, 4'h4);
    rd(OFF_DATA_HI, b[7:4]);
    wr(OFF_CTRL, 4'h0);
    // synchronous master transmit; a receive trigger while it runs must be refused
    wr(OFF_MODE, 4'h0);
    wr(OFF_MASK, 4'h2);
    wr(OFF_CTRL, 4'h3);
    wr(OFF_CTRL, 4'hd);
    rd(OFF_CTRL, 4'h7);
    @(negedge CLOCK);
    check("sclk oe", {7'h0, SCLK_OE}, 8'h01);
    wait_irq();
    rd(OFF_CTRL, 4'h5);
    wr(OFF_FLAG_CLR, 4'h2);
    rd(OFF_FLAGS, 4'h0);
    wr(OFF_CTRL, 4'h0);
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    check("sclk oe idle", {7'h0, SCLK_OE}, 8'h00);
    summarize();
  end
endmodule // spic_top_bench
`default_nettype wire
